// File: hw/pmicr_pkg.sv
package pmicr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_TIME_MS = 1;
  localparam int unsigned CYC_PER_MS = (CLK_HZ / 1000) * TICK_TIME_MS;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets and reset values
  localparam logic [7:0] OFS_AUX = 8'h07;
  localparam logic [7:0] OFS_PB = 8'h08;
  localparam logic [7:0] OFS_CURRENT_LIMIT_PIN = 8'h09;
  localparam logic [7:0] OFS_MON = 8'h0a;
  localparam logic [7:0] RST_AUX = 8'h28;
  localparam logic [7:0] RST_PB = 8'h68;
  localparam logic [7:0] RST_CURRENT_LIMIT_PIN = 8'h0a;
  localparam logic [7:0] RST_MON = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'hfd;
  localparam logic [7:0] PB_WMASK = 8'hfc;
  localparam logic [7:0] CURRENT_LIMIT_PIN_WMASK = 8'h7f;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned AUX_EN_BIT = 7;
  localparam int unsigned AUX_CODE_LSB = 2;
  localparam int unsigned AUX_VIN_BIT = 0;
  localparam int unsigned PB_W1_BIT = 7;
  localparam int unsigned PB_W2_BIT = 6;
  localparam int unsigned PB_REC_BIT = 5;
  localparam int unsigned PB_HOLD_LSB = 3;
  localparam int unsigned PB_PIN_BIT = 2;
  localparam int unsigned PB_F1_BIT = 1;
  localparam int unsigned PB_F2_BIT = 0;
  localparam int unsigned CURRENT_LIMIT_PIN_RST_BIT = 7;
  localparam int unsigned CURRENT_LIMIT_PIN_LSB = 3;
  localparam int unsigned BUV_LSB = 0;
  localparam int unsigned MON_TRIG_BIT = 7;
  localparam int unsigned MON_RANGE_LSB = 5;
  localparam int unsigned MON_LEVEL_LSB = 2;
  localparam logic [4:0] AUX_PASS_CODE = 5'h19;

  ////////////////////////////////////////////////////////////////////////////
  // press thresholds in milliseconds
  localparam logic [13:0] SHORT_PRESS_FLAG_SHORT_MS = 14'h0050;
  localparam logic [13:0] SHORT_PRESS_FLAG_LONG_MS = 14'h0258;
  localparam logic [13:0] LONG_PRESS_FLAG_SHORT_MS = 14'h03e8;
  localparam logic [13:0] LONG_PRESS_FLAG_LONG_MS = 14'h05dc;
  localparam logic [13:0] HOLD_5S_MS = 14'h1388;
  localparam logic [13:0] HOLD_9S_MS = 14'h2328;
  localparam logic [13:0] HOLD_11S_MS = 14'h2af8;
  localparam logic [13:0] HOLD_15S_MS = 14'h3a98;
  localparam logic [13:0] PRESS_CAP_MS = 14'h3fff;

  ////////////////////////////////////////////////////////////////////////////
  // serial port
  localparam logic [6:0] I2C_ADDR = 7'h35;  // arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int unsigned SYNC_W = 12;
  // scl, sda and the two active-low pins idle high, so no false edge follows reset
  localparam logic [11:0] SYNC_IDLE = 12'hf00;

  typedef enum logic [3:0] {
    PMICR_IDLE, PMICR_ADDR, PMICR_ADDR_ACK, PMICR_PTR, PMICR_PTR_ACK,
    PMICR_WDATA, PMICR_WACK, PMICR_RDATA, PMICR_RACK
  } pmicr_i2c_st_t;

  typedef struct packed {
    logic [1:0] range;
    logic [2:0] level;
  } pmicr_mon_t;

  typedef struct packed {
    logic aux_output_enable;
    logic [4:0] aux_voltage_code;
    logic aux_passthrough;
    logic post_reset_hiz;
    logic [2:0] input_current_limit_code;
    logic current_limit_pin_from_pin;
    logic [2:0] battery_undervoltage_threshold;
  } pmicr_cfg_t;

  typedef struct packed {
    pmicr_i2c_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] ptr;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic [7:0] aux;
    logic [7:0] pb;
    logic [7:0] current_limit_pin;
    logic [7:0] mon;
    logic input_current_limit_code_written;
    logic [13:0] press_ms;
    logic reset_done;
    logic dev_reset;
    logic mon_start;
    logic status_n;
    pmicr_cfg_t cfg;
  } pmicr_state_t;

endpackage

// File: hw/pmicr_sync.sv
`timescale 1ns/1ps
module pmicr_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] IDLE_VAL = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // stage 0 is read only by stage 1
  logic [1:0][W-1:0] s_r;
  logic [1:0][W-1:0] s_nxt;

  always_comb
  begin
    s_nxt[0] = i_async;
    s_nxt[1] = s_r[0];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= {IDLE_VAL, IDLE_VAL};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r[1];

endmodule

// File: hw/pmicr_tick.sv
`timescale 1ns/1ps
module pmicr_tick #(
  parameter int unsigned PERIOD = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // enable pulse
  output logic o_tick
);

  localparam int unsigned CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } pmicr_tick_state_t;

  pmicr_tick_state_t s_r;
  pmicr_tick_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == CW'(PERIOD - 1))
    begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_tick = s_r.tick;

endmodule

// File: hw/pmicr_bank.sv
`timescale 1ns/1ps
module pmicr_bank #(
  parameter int unsigned CYC_PER_MS = pmicr_pkg::CYC_PER_MS,
  parameter logic [6:0] I2C_ADDR = pmicr_pkg::I2C_ADDR
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // serial register port
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // push-button and status pin
  input wire logic i_pushbutton_input_n,
  input wire logic i_power_good_n,
  input wire logic i_input_valid,
  output logic o_status_pin_n,
  output logic o_device_reset,
  // current-limit pin
  input wire logic i_current_limit_pin_fitted,
  // battery monitor
  input pmicr_pkg::pmicr_mon_t i_mon,
  input wire logic i_mon_done,
  output logic o_battery_monitor_trigger,
  // configuration to the analog side
  output pmicr_pkg::pmicr_cfg_t o_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and millisecond tick
  logic [pmicr_pkg::SYNC_W-1:0] sy;
  logic tick, sy_scl, sy_sda, sy_pb_n, sy_pg_n, sy_valid, sy_fitted, sy_done;
  pmicr_pkg::pmicr_mon_t sy_mon;

  pmicr_sync #(
    .W(pmicr_pkg::SYNC_W),
    .IDLE_VAL(pmicr_pkg::SYNC_IDLE)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_scl, i_sda_in, i_pushbutton_input_n, i_power_good_n, i_input_valid,
              i_current_limit_pin_fitted, i_mon_done, i_mon}),
    .o_sync(sy)
  );

  assign {sy_scl, sy_sda, sy_pb_n, sy_pg_n, sy_valid, sy_fitted, sy_done, sy_mon} = sy;

  pmicr_tick #(
    .PERIOD(CYC_PER_MS)
  ) u_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  pmicr_pkg::pmicr_state_t s_r;
  pmicr_pkg::pmicr_state_t s_nxt;

  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic do_wr, load_rd, pressed;
  logic [7:0] rb;
  logic [13:0] inc, th1, th2, hold;

  assign scl_rise = sy_scl & ~s_r.scl_q;
  assign scl_fall = ~sy_scl & s_r.scl_q;
  assign start_cond = s_r.scl_q & sy_scl & s_r.sda_q & ~sy_sda;
  assign stop_cond = s_r.scl_q & sy_scl & ~s_r.sda_q & sy_sda;
  assign pressed = ~sy_pb_n;

  always_comb
  begin
    s_nxt = s_r;
    do_wr = 1'b0;
    load_rd = 1'b0;
    rb = 8'h00;
    inc = s_r.press_ms + 14'h0001;
    s_nxt.dev_reset = 1'b0;
    s_nxt.mon_start = 1'b0;
    s_nxt.scl_q = sy_scl;
    s_nxt.sda_q = sy_sda;

    //////////////////////////////////////////////////////////////////////////
    // serial byte engine
    case (s_r.st)
      pmicr_pkg::PMICR_IDLE: s_nxt.sda_oe = 1'b0;
      pmicr_pkg::PMICR_ADDR:
      begin
        if (scl_rise)
        begin
          s_nxt.shreg = {s_r.shreg[6:0], sy_sda};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        else if (scl_fall && s_r.bitcnt == pmicr_pkg::BYTE_BITS)
        begin
          if (s_r.shreg[7:1] == I2C_ADDR)
          begin
            s_nxt.sda_oe = 1'b1;
            s_nxt.rw = s_r.shreg[0];
            s_nxt.st = pmicr_pkg::PMICR_ADDR_ACK;
          end
          else
            s_nxt.st = pmicr_pkg::PMICR_IDLE;
        end
      end
      pmicr_pkg::PMICR_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rw)
            load_rd = 1'b1;
          else
          begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = pmicr_pkg::PMICR_PTR;
          end
        end
      end
      pmicr_pkg::PMICR_PTR:
      begin
        if (scl_rise)
        begin
          s_nxt.shreg = {s_r.shreg[6:0], sy_sda};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        else if (scl_fall && s_r.bitcnt == pmicr_pkg::BYTE_BITS)
        begin
          s_nxt.ptr = s_r.shreg;
          s_nxt.sda_oe = 1'b1;
          s_nxt.st = pmicr_pkg::PMICR_PTR_ACK;
        end
      end
      pmicr_pkg::PMICR_PTR_ACK,
      pmicr_pkg::PMICR_WACK:
      begin
        if (scl_fall)
        begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.st = pmicr_pkg::PMICR_WDATA;
        end
      end
      pmicr_pkg::PMICR_WDATA:
      begin
        if (scl_rise)
        begin
          s_nxt.shreg = {s_r.shreg[6:0], sy_sda};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        else if (scl_fall && s_r.bitcnt == pmicr_pkg::BYTE_BITS)
        begin
          do_wr = 1'b1;
          s_nxt.ptr = s_r.ptr + 8'h01;
          s_nxt.sda_oe = 1'b1;
          s_nxt.st = pmicr_pkg::PMICR_WACK;
        end
      end
      pmicr_pkg::PMICR_RDATA:
      begin
        if (scl_rise)
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        else if (scl_fall)
        begin
          if (s_r.bitcnt == pmicr_pkg::BYTE_BITS)
          begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.st = pmicr_pkg::PMICR_RACK;
          end
          else
          begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.shreg[6];
          end
        end
      end
      pmicr_pkg::PMICR_RACK:
      begin
        // a not-acknowledge ends the read burst
        if (scl_rise && sy_sda)
          s_nxt.st = pmicr_pkg::PMICR_IDLE;
        else if (scl_fall)
        begin
          s_nxt.bitcnt = 4'h0;
          load_rd = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = pmicr_pkg::PMICR_IDLE;
        s_nxt.sda_oe = 1'b0;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // read path: unmapped offsets read 0x00
    case (s_r.ptr)
      pmicr_pkg::OFS_AUX: rb = s_r.aux;
      pmicr_pkg::OFS_PB: rb = s_r.pb;
      pmicr_pkg::OFS_CURRENT_LIMIT_PIN: rb = s_r.current_limit_pin;
      pmicr_pkg::OFS_MON: rb = s_r.mon;
      default: rb = 8'h00;
    endcase

    if (load_rd)
    begin
      s_nxt.shreg = rb;
      s_nxt.sda_oe = ~rb[7];
      s_nxt.st = pmicr_pkg::PMICR_RDATA;
      if (s_r.ptr == pmicr_pkg::OFS_PB)
      begin
        s_nxt.pb[pmicr_pkg::PB_F1_BIT] = 1'b0;
        s_nxt.pb[pmicr_pkg::PB_F2_BIT] = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // write path
    if (do_wr)
    begin
      case (s_r.ptr)
        pmicr_pkg::OFS_AUX: s_nxt.aux = s_r.shreg & pmicr_pkg::AUX_WMASK;
        pmicr_pkg::OFS_PB: s_nxt.pb = (s_r.shreg & pmicr_pkg::PB_WMASK) | (s_nxt.pb & ~pmicr_pkg::PB_WMASK);
        pmicr_pkg::OFS_CURRENT_LIMIT_PIN:
        begin
          if (s_r.shreg[pmicr_pkg::CURRENT_LIMIT_PIN_RST_BIT])
          begin
            s_nxt.aux = pmicr_pkg::RST_AUX;
            s_nxt.pb = pmicr_pkg::RST_PB;
            s_nxt.current_limit_pin = pmicr_pkg::RST_CURRENT_LIMIT_PIN;
            s_nxt.mon = pmicr_pkg::RST_MON;
            s_nxt.input_current_limit_code_written = 1'b0;
          end
          else
          begin
            s_nxt.current_limit_pin = s_r.shreg & pmicr_pkg::CURRENT_LIMIT_PIN_WMASK;
            s_nxt.input_current_limit_code_written = 1'b1;
          end
        end
        pmicr_pkg::OFS_MON: s_nxt.mon_start = s_r.shreg[pmicr_pkg::MON_TRIG_BIT];
        default: s_nxt.mon_start = 1'b0;
      endcase
    end

    // bus conditions override the byte engine
    if (start_cond)
    begin
      s_nxt.st = pmicr_pkg::PMICR_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      s_nxt.st = pmicr_pkg::PMICR_IDLE;
      s_nxt.sda_oe = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // battery monitor result capture
    if (sy_done)
    begin
      s_nxt.mon[pmicr_pkg::MON_RANGE_LSB +: 2] = sy_mon.range;
      s_nxt.mon[pmicr_pkg::MON_LEVEL_LSB +: 3] = sy_mon.level;
      s_nxt.mon[pmicr_pkg::MON_TRIG_BIT] = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // push-button timing
    th1 = s_r.pb[pmicr_pkg::PB_W1_BIT] ? pmicr_pkg::SHORT_PRESS_FLAG_LONG_MS : pmicr_pkg::SHORT_PRESS_FLAG_SHORT_MS;
    th2 = s_r.pb[pmicr_pkg::PB_W2_BIT] ? pmicr_pkg::LONG_PRESS_FLAG_LONG_MS : pmicr_pkg::LONG_PRESS_FLAG_SHORT_MS;
    case (s_r.pb[pmicr_pkg::PB_HOLD_LSB +: 2])
      2'h0: hold = pmicr_pkg::HOLD_5S_MS;
      2'h1: hold = pmicr_pkg::HOLD_9S_MS;
      2'h2: hold = pmicr_pkg::HOLD_11S_MS;
      default: hold = pmicr_pkg::HOLD_15S_MS;
    endcase

    if (!pressed)
    begin
      s_nxt.press_ms = 14'h0000;
      s_nxt.reset_done = 1'b0;
    end
    else
    begin
      if (tick && s_r.press_ms != pmicr_pkg::PRESS_CAP_MS)
      begin
        s_nxt.press_ms = inc;
        // flag sets land after the read clear, so an event is never lost
        if (inc == th1)
          s_nxt.pb[pmicr_pkg::PB_F1_BIT] = 1'b1;
        if (inc == th2)
          s_nxt.pb[pmicr_pkg::PB_F2_BIT] = 1'b1;
      end
      if (!s_r.reset_done && s_r.press_ms >= hold &&
          (!s_r.aux[pmicr_pkg::AUX_VIN_BIT] || sy_valid))
      begin
        s_nxt.dev_reset = 1'b1;
        s_nxt.reset_done = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // registered outputs
    s_nxt.status_n = s_r.pb[pmicr_pkg::PB_PIN_BIT] ? sy_pb_n : sy_pg_n;
    s_nxt.cfg.aux_output_enable = s_nxt.aux[pmicr_pkg::AUX_EN_BIT];
    s_nxt.cfg.aux_voltage_code = s_nxt.aux[pmicr_pkg::AUX_CODE_LSB +: 5];
    s_nxt.cfg.aux_passthrough = s_nxt.aux[pmicr_pkg::AUX_CODE_LSB +: 5] > pmicr_pkg::AUX_PASS_CODE;
    s_nxt.cfg.post_reset_hiz = s_nxt.pb[pmicr_pkg::PB_REC_BIT];
    s_nxt.cfg.input_current_limit_code = s_nxt.current_limit_pin[pmicr_pkg::CURRENT_LIMIT_PIN_LSB +: 3];
    s_nxt.cfg.current_limit_pin_from_pin = sy_fitted & ~s_nxt.input_current_limit_code_written;
    s_nxt.cfg.battery_undervoltage_threshold = s_nxt.current_limit_pin[pmicr_pkg::BUV_LSB +: 3];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= '0;
      s_r.st <= pmicr_pkg::PMICR_IDLE;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      s_r.status_n <= 1'b1;
      s_r.aux <= pmicr_pkg::RST_AUX;
      s_r.pb <= pmicr_pkg::RST_PB;
      s_r.current_limit_pin <= pmicr_pkg::RST_CURRENT_LIMIT_PIN;
      s_r.mon <= pmicr_pkg::RST_MON;
      s_r.cfg.aux_voltage_code <= pmicr_pkg::RST_AUX[pmicr_pkg::AUX_CODE_LSB +: 5];
      s_r.cfg.post_reset_hiz <= pmicr_pkg::RST_PB[pmicr_pkg::PB_REC_BIT];
      s_r.cfg.input_current_limit_code <= pmicr_pkg::RST_CURRENT_LIMIT_PIN[pmicr_pkg::CURRENT_LIMIT_PIN_LSB +: 3];
      s_r.cfg.battery_undervoltage_threshold <= pmicr_pkg::RST_CURRENT_LIMIT_PIN[pmicr_pkg::BUV_LSB +: 3];
    end
    else
      s_r <= s_nxt;
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = s_r.sda_oe;
  assign o_status_pin_n = s_r.status_n;
  assign o_device_reset = s_r.dev_reset;
  assign o_battery_monitor_trigger = s_r.mon_start;
  assign o_cfg = s_r.cfg;

endmodule

// File: testbench/pmicr_bank_sva.sv
`timescale 1ns/1ps
module pmicr_bank_chk #(
  parameter int unsigned CYC_PER_MS = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // watched pins
  input wire logic i_scl,
  input wire logic i_pushbutton_input_n,
  input wire logic i_power_good_n,
  input wire logic o_sda_oe,
  input wire logic o_status_pin_n,
  input wire logic o_device_reset,
  input wire logic o_battery_monitor_trigger,
  input pmicr_pkg::pmicr_cfg_t o_cfg
);
  // first ms tick may come early, so one ms of slack
  localparam int HOLD_MIN = int'(4999 * CYC_PER_MS);
  logic [5:0] low_hist;
  int press_cyc;
  logic fired;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      low_hist <= 6'h00;
      press_cyc <= 0;
      fired <= 1'b0;
    end
    else
    begin
      low_hist <= {low_hist[4:0], ~i_power_good_n | ~i_pushbutton_input_n};
      press_cyc <= i_pushbutton_input_n ? 0 : press_cyc + 1;
      fired <= i_pushbutton_input_n ? 1'b0 : (fired | o_device_reset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_oe_held;
    o_sda_oe [*8];
  endsequence
  sequence s_trig_gone;
    !o_battery_monitor_trigger;
  endsequence

  a_cfg_reset_state:
    assert property ($rose(i_reset_n) |-> !o_cfg.aux_output_enable && o_cfg.aux_voltage_code == 5'h0a
      && o_cfg.post_reset_hiz && o_cfg.input_current_limit_code == 3'h1 && o_cfg.battery_undervoltage_threshold == 3'h2)
    else $error("config not at defaults after reset");
  a_pass_code:
    assert property (o_cfg.aux_passthrough == (o_cfg.aux_voltage_code > 5'h19))
    else $error("passthrough does not match voltage code");
  a_cfg_on_write:
    assert property ($changed({o_cfg.aux_output_enable, o_cfg.aux_voltage_code, o_cfg.battery_undervoltage_threshold})
      |-> !i_scl)
    else $error("config changed outside a data slot");
  a_status_cause:
    assert property (!o_status_pin_n |-> |low_hist)
    else $error("status pin low without a low source");
  a_trig_pulse:
    assert property (o_battery_monitor_trigger |-> !i_scl ##1 s_trig_gone)
    else $error("monitor trigger not a single write pulse");
  a_rst_pulse:
    assert property (o_device_reset |=> !o_device_reset)
    else $error("device reset longer than one cycle");
  a_rst_hold_min:
    assert property (o_device_reset |-> press_cyc >= HOLD_MIN)
    else $error("device reset before shortest hold time");
  a_rst_once:
    assert property (o_device_reset |-> !fired)
    else $error("second device reset in one press");
  a_sda_scl_low:
    assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while clock high");
  a_ack_held:
    assert property ($rose(o_sda_oe) |-> s_oe_held)
    else $error("data line low drive too short");
endmodule

bind pmicr_bank pmicr_bank_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_pushbutton_input_n(i_pushbutton_input_n),
  .i_power_good_n(i_power_good_n), .o_sda_oe(o_sda_oe), .o_status_pin_n(o_status_pin_n),
  .o_device_reset(o_device_reset), .o_battery_monitor_trigger(o_battery_monitor_trigger), .o_cfg(o_cfg)
);

// File: testbench/pmicr_host.sv
`timescale 1ns/1ps
module pmicr_host #(
  parameter logic [6:0] ADDR = pmicr_pkg::I2C_ADDR
) (
  // clock
  input wire logic i_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  int nack_cnt;

  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    nack_cnt = 0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // scl low on entry and exit; data sampled late in the high phase
  task automatic clk_bit(input logic d, output logic b);
    o_sda_oe <= ~d;
    hold(10);
    o_scl <= 1'b1;
    hold(9);
    b = i_sda;
    hold(1);
    o_scl <= 1'b0;
    hold(2);
  endtask

  // also serves as repeated start
  task automatic start;
    o_sda_oe <= 1'b0;
    hold(10);
    o_scl <= 1'b1;
    hold(10);
    o_sda_oe <= 1'b1;
    hold(10);
    o_scl <= 1'b0;
    hold(2);
  endtask

  task automatic stop;
    o_sda_oe <= 1'b1;
    hold(10);
    o_scl <= 1'b1;
    hold(10);
    o_sda_oe <= 1'b0;
    hold(10);
  endtask

  // ack slot always released: device ack on writes, host nack on the single read
  task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], b);
      q[i] = b;
    end
    clk_bit(1'b1, b);
    if (!rd && b)
      nack_cnt++;
  endtask

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({ADDR, 1'b0}, 1'b0, q);
    xfer(ofs, 1'b0, q);
    xfer(d, 1'b0, q);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({ADDR, 1'b0}, 1'b0, q);
    xfer(ofs, 1'b0, q);
    start();
    xfer({ADDR, 1'b1}, 1'b0, q);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask
endmodule

// File: testbench/pmicr_bank_tb_top.sv
`timescale 1ns/1ps
module pmicr_bank_tb_top;
  localparam int unsigned CPM = 4;
  logic i_clk;
  logic i_reset_n;
  logic scl;
  logic host_oe;
  logic sda_out;
  logic sda_oe;
  logic pb_n;
  logic pg_n;
  logic in_valid;
  logic lim_fit;
  logic mon_done;
  logic st_n;
  logic dev_rst;
  logic trig;
  wire sda;
  pmicr_pkg::pmicr_mon_t mon;
  pmicr_pkg::pmicr_cfg_t cfg;
  int err_count;
  int checked;
  int rst_seen;
  int trig_seen;
  logic [7:0] rd;

  // open-drain data line with pull-up
  assign sda = ~((sda_oe & ~sda_out) | host_oe);

  pmicr_bank #(.CYC_PER_MS(CPM)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_pushbutton_input_n(pb_n), .i_power_good_n(pg_n), .i_input_valid(in_valid), .o_status_pin_n(st_n),
    .o_device_reset(dev_rst), .i_current_limit_pin_fitted(lim_fit), .i_mon(mon), .i_mon_done(mon_done),
    .o_battery_monitor_trigger(trig), .o_cfg(cfg)
  );
  pmicr_host u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    if (dev_rst === 1'b1)
      rst_seen++;
    if (trig === 1'b1)
      trig_seen++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp, input string what);
    u_host.read_reg(ofs, rd);
    chk(what, exp, rd);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rdchk(pmicr_pkg::OFS_AUX, 8'h28, "aux reset");
    rdchk(pmicr_pkg::OFS_PB, 8'h68, "pb reset");
    rdchk(pmicr_pkg::OFS_CURRENT_LIMIT_PIN, 8'h0a, "current_limit_pin reset");
    rdchk(pmicr_pkg::OFS_MON, 8'h00, "mon reset");
    rdchk(8'h0b, 8'h00, "unmapped read");
    chk("limit from pin", 8'h01, {7'h00, cfg.current_limit_pin_from_pin});
    lim_fit <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("limit without resistor", 8'h00, {7'h00, cfg.current_limit_pin_from_pin});
    lim_fit <= 1'b1;
    $display("test defaults done");
  endtask

  task automatic t_access;
    u_host.write_reg(8'h07, 8'hff);
    rdchk(8'h07, 8'hfd, "aux rw bits");
    chk("aux enable", 8'h01, {7'h00, cfg.aux_output_enable});
    u_host.write_reg(8'h08, 8'hdf);
    rdchk(8'h08, 8'hdc, "pb rw bits");
    chk("post reset hiz", 8'h00, {7'h00, cfg.post_reset_hiz});
    u_host.write_reg(8'h09, 8'h7f);
    rdchk(8'h09, 8'h7f, "current_limit_pin rw bits");
    chk("limit from pin", 8'h00, {7'h00, cfg.current_limit_pin_from_pin});
    u_host.write_reg(8'h0a, 8'h80);
    chk("trigger pulses", 8'h01, trig_seen[7:0]);
    rdchk(8'h0a, 8'h00, "mon trigger bit");
    u_host.write_reg(8'h09, 8'h80);
    rdchk(8'h07, 8'h28, "aux after reset all");
    rdchk(8'h08, 8'h68, "pb after reset all");
    rdchk(8'h09, 8'h0a, "current_limit_pin after reset all");
    $display("test access done");
  endtask

  task automatic t_codes;
    for (int c = 24; c < 28; c++)
    begin
      u_host.write_reg(8'h07, {1'b0, c[4:0], 2'b00});
      chk("aux code", 8'(c), {3'h0, cfg.aux_voltage_code});
      chk("passthrough", {7'h00, (8 + c) > 33}, {7'h00, cfg.aux_passthrough});
      chk("aux disabled", 8'h00, {7'h00, cfg.aux_output_enable});
    end
    for (int i = 0; i < 8; i++)
    begin
      u_host.write_reg(8'h09, {2'b00, 3'(7 - i), 3'(i)});
      chk("uv threshold", 8'(i), {5'h00, cfg.battery_undervoltage_threshold});
      chk("limit code", 8'(7 - i), {5'h00, cfg.input_current_limit_code});
    end
    $display("test codes done");
  endtask

  task automatic t_monitor;
    mon <= 5'b10011;
    mon_done <= 1'b1;
    repeat (4) @(posedge i_clk);
    mon_done <= 1'b0;
    mon <= 5'b01100;
    rdchk(8'h0a, 8'h4c, "monitor result");
    $display("test monitor done");
  endtask

  task automatic t_status;
    u_host.write_reg(8'h08, 8'h68);
    pg_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("status shows pg", 8'h00, {7'h00, st_n});
    pg_n <= 1'b1;
    pb_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("status ignores button", 8'h01, {7'h00, st_n});
    pb_n <= 1'b1;
    u_host.write_reg(8'h08, 8'h6c);
    pb_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("status shows button", 8'h00, {7'h00, st_n});
    pb_n <= 1'b1;
    $display("test status done");
  endtask

  task automatic t_press;
    int n;
    u_host.write_reg(8'h07, 8'h29);
    u_host.write_reg(8'h08, 8'h44);
    in_valid <= 1'b0;
    pb_n <= 1'b0;
    repeat (5000 * CPM + 200) @(posedge i_clk);
    chk("reset while input invalid", 8'h00, rst_seen[7:0]);
    in_valid <= 1'b1;
    n = 0;
    while (rst_seen == 0 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n == 20)
    begin
      err_count++;
      $display("[ERR] reset pulse expected 1 seen 0");
      give_verdict();
    end
    repeat (20) @(posedge i_clk);
    chk("resets per press", 8'h01, rst_seen[7:0]);
    pb_n <= 1'b1;
    rdchk(8'h08, 8'h47, "wake flags set");
    rdchk(8'h08, 8'h44, "wake flags cleared");
    u_host.write_reg(8'h07, 8'h28);
    in_valid <= 1'b0;
    pb_n <= 1'b0;
    repeat (5000 * CPM + 200) @(posedge i_clk);
    pb_n <= 1'b1;
    in_valid <= 1'b1;
    chk("reset without input check", 8'h02, rst_seen[7:0]);
    $display("test press done");
  endtask

  initial
  begin
    i_reset_n = 1'b0;
    pb_n = 1'b1;
    pg_n = 1'b1;
    in_valid = 1'b1;
    lim_fit = 1'b1;
    mon_done = 1'b0;
    mon = 5'h00;
    err_count = 0;
    checked = 0;
    rst_seen = 0;
    trig_seen = 0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_defaults();
    t_access();
    t_codes();
    t_monitor();
    t_status();
    t_press();
    chk("missing acks", 8'h00, u_host.nack_cnt[7:0]);
    give_verdict();
  end
endmodule
